// >>> aif_filter_status.v
// Analog input filter, sample timing and status word packing for eight channels
`timescale 1ns/10ps
`include "aif_defs.vh"

module aif_filter_status
#(
  parameter integer P_FIR50_CYC = `AIF_T_FIR50_NS / `AIF_CLK_PERIOD_NS,
  parameter integer P_FIR60_CYC = `AIF_T_FIR60_NS / `AIF_CLK_PERIOD_NS,
  parameter integer P_IIR_CYC   = `AIF_T_IIR_NS / `AIF_CLK_PERIOD_NS
)
(
  input  wire         i_clock,
  input  wire         i_arst_n,
  input  wire [7:0]   i_s_axi_awaddr,
  input  wire [2:0]   i_s_axi_awprot,
  input  wire         i_s_axi_awvalid,
  output wire         o_s_axi_awready,
  input  wire [31:0]  i_s_axi_wdata,
  input  wire [3:0]   i_s_axi_wstrb,
  input  wire         i_s_axi_wvalid,
  output wire         o_s_axi_wready,
  output wire [1:0]   o_s_axi_bresp,
  output wire         o_s_axi_bvalid,
  input  wire         i_s_axi_bready,
  input  wire [7:0]   i_s_axi_araddr,
  input  wire [2:0]   i_s_axi_arprot,
  input  wire         i_s_axi_arvalid,
  output wire         o_s_axi_arready,
  output wire [31:0]  o_s_axi_rdata,
  output wire [1:0]   o_s_axi_rresp,
  output wire         o_s_axi_rvalid,
  input  wire         i_s_axi_rready,
  input  wire         i_frame_strobe,
  input  wire         i_dc_sync,
  input  wire         i_sync_error,
  input  wire         i_internal_fault,
  output wire         o_adc_start,
  input  wire         i_adc_done,
  input  wire [127:0] i_adc_data,
  output wire         o_image_update,
  output wire [127:0] o_image_value,
  output wire [127:0] o_image_status,
  output wire         o_image_status_en
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_CONV = 3'b010;
  localparam [2:0] S_PUB  = 3'b100;

  reg  [1:0]  rst_pipe_reg;
  wire        rst_n;
  reg  [15:0] ctrl_reg;
  reg  [15:0] lim1_reg;
  reg  [15:0] lim2_reg;
  reg  [15:0] upper_reg;
  reg  [15:0] lower_reg;
  reg         aw_full_reg;
  reg  [7:0]  aw_addr_reg;
  reg         w_full_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         bvalid_reg;
  reg  [1:0]  bresp_reg;
  reg         rvalid_reg;
  reg  [31:0] rdata_reg;
  reg  [1:0]  rresp_reg;
  reg  [31:0] rd_next;
  reg  [1:0]  rresp_next;
  reg  [15:0] ctrl_next;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [16:0] timer_reg;
  reg         start_reg;
  reg         update_reg;
  reg         sync_seen_reg;
  wire        filt_on;
  wire        dc_on;
  wire        compact;
  wire        inv_sense;
  wire [3:0]  filt_char;
  wire        is_iir;
  wire [3:0]  iir_lvl;
  wire [16:0] period;
  wire        tick;
  wire        trig;
  wire        capture;
  wire        publish;
  wire        freerun_eff;
  wire        fast_operation_option_eff;
  wire [127:0] img_val_flat;
  wire [127:0] img_sw_flat;
  wire [2:0]  rd_ch;

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] dat;
    input [1:0]  strb;
    begin
      merge16 = {strb[1] ? dat[15:8] : old[15:8], strb[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  function [1:0] lim_code;
    input               en;
    input signed [15:0] v;
    input signed [15:0] l;
    input               inv;
    begin
      if (!en)
        lim_code = `AIF_LIM_OFF;
      else if (v == l)
        lim_code = `AIF_LIM_EQUAL;
      else if ((v < l) ^ inv)
        lim_code = `AIF_LIM_BELOW;
      else
        lim_code = `AIF_LIM_ABOVE;
    end
  endfunction

  // Release of the asynchronous reset is retimed to the clock
  always @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rst_pipe_reg <= 2'b00;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  assign rst_n = rst_pipe_reg[1];

  // Channel modes come only from the control register ctrl_reg
  assign filt_on   = ctrl_reg[`AIF_CTRL_FILT];
  assign dc_on     = ctrl_reg[`AIF_CTRL_DC];
  assign compact   = ctrl_reg[`AIF_CTRL_COMPACT];
  assign inv_sense = ctrl_reg[`AIF_CTRL_INV];
  assign filt_char = ctrl_reg[`AIF_CTRL_CHAR_HI:`AIF_CTRL_CHAR_LO];
  assign is_iir    = (filt_char >= `AIF_CHAR_IIR1) && (filt_char <= `AIF_CHAR_IIR8);
  assign iir_lvl   = filt_char - 4'h1;
  assign freerun_eff = filt_on;
  assign fast_operation_option_eff  = ctrl_reg[`AIF_CTRL_FAST] & ~filt_on & ~dc_on;

  // Free-run sample timer; the period follows the notch or the IIR rate
  assign period = is_iir ? P_IIR_CYC[16:0] :
                  (filt_char == `AIF_CHAR_FIR60) ? P_FIR60_CYC[16:0] :
                  P_FIR50_CYC[16:0];
  assign tick = (timer_reg == 17'h00000);

  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
      timer_reg <= 17'h00000;
    else if (!filt_on || tick)
      timer_reg <= period - 17'h00001;
    else
      timer_reg <= timer_reg - 17'h00001;
  end

  // A trigger arriving while a conversion runs is dropped, not queued
  assign trig = filt_on ? tick :
                dc_on ? i_dc_sync :
                i_frame_strobe;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (trig)
          state_next = S_CONV;
      end
      S_CONV:
      begin
        if (i_adc_done)
          state_next = S_PUB;
      end
      S_PUB:
        state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  assign capture = (state_reg == S_CONV) && i_adc_done;
  // Results go out the cycle after conversion so the shifted sync leaves them ready in time
  assign publish = (state_reg == S_PUB);

  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= S_IDLE;
      start_reg     <= 1'b0;
      update_reg    <= 1'b0;
      sync_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      start_reg  <= (state_reg == S_IDLE) && trig;
      update_reg <= publish;
      if (publish)
      begin
        // An error in the publish cycle is carried into the next word: set wins
        sync_seen_reg <= i_sync_error;
      end
      else if (i_sync_error)
        sync_seen_reg <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `AIF_NCH; g = g + 1)
    begin : g_ch
      wire signed [15:0] x;
      wire signed [23:0] x_fx;
      wire signed [24:0] diff;
      wire signed [24:0] step;
      wire signed [23:0] iir_next;
      wire signed [17:0] fir_sum;
      wire signed [15:0] fir_y;
      wire signed [15:0] filt_y;
      wire               over;
      wire               under;
      reg  signed [15:0] t1_reg;
      reg  signed [15:0] t2_reg;
      reg  signed [15:0] t3_reg;
      reg  signed [23:0] iir_reg;
      reg  signed [15:0] val_reg;
      reg  [15:0]        img_val_reg;
      reg  [15:0]        img_sw_reg;
      reg                tog_reg;
      reg  [15:0]        sw_next;

      assign x       = i_adc_data[16*g +: 16];
      assign x_fx    = {x, 8'h00};
      // Four-tap boxcar: nulls at the notch and its multiples, no feedback
      assign fir_sum = x + t1_reg + t2_reg + t3_reg;
      assign fir_y   = fir_sum[17:2];
      assign diff    = x_fx - iir_reg;
      assign step    = diff >>> iir_lvl;
      assign iir_next = iir_reg + step[23:0];
      assign filt_y  = !filt_on ? x : is_iir ? iir_next[23:8] : fir_y;
      assign over    = val_reg > $signed(upper_reg);
      assign under   = val_reg < $signed(lower_reg);

      always @*
      begin
        sw_next = 16'h0000;
        sw_next[`AIF_SW_TOGGLE] = ~tog_reg;
        sw_next[`AIF_SW_FAULT]  = i_internal_fault;
        sw_next[`AIF_SW_SYNC]   = dc_on & sync_seen_reg;
        sw_next[`AIF_SW_ERR]    = over | under;
        sw_next[`AIF_SW_LIM2+1:`AIF_SW_LIM2] =
          lim_code(ctrl_reg[`AIF_CTRL_LIM2EN], val_reg, lim2_reg, inv_sense);
        sw_next[`AIF_SW_LIM1+1:`AIF_SW_LIM1] =
          lim_code(ctrl_reg[`AIF_CTRL_LIM1EN], val_reg, lim1_reg, inv_sense);
        sw_next[`AIF_SW_OVER]   = over;
        sw_next[`AIF_SW_UNDER]  = under;
      end

      always @(posedge i_clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          t1_reg      <= 16'h0000;
          t2_reg      <= 16'h0000;
          t3_reg      <= 16'h0000;
          iir_reg     <= 24'h000000;
          val_reg     <= 16'h0000;
          img_val_reg <= 16'h0000;
          img_sw_reg  <= 16'h0000;
          tog_reg     <= 1'b0;
        end
        else
        begin
          if (capture)
          begin
            t1_reg  <= x;
            t2_reg  <= t1_reg;
            t3_reg  <= t2_reg;
            // Outside IIR mode the state tracks the input so a switch starts settled
            iir_reg <= (filt_on && is_iir) ? iir_next : x_fx;
            val_reg <= filt_y;
          end
          if (publish)
          begin
            img_val_reg <= val_reg;
            tog_reg     <= ~tog_reg;
            img_sw_reg  <= compact ? 16'h0000 : sw_next;
          end
        end
      end

      assign img_val_flat[16*g +: 16] = img_val_reg;
      assign img_sw_flat[16*g +: 16]  = img_sw_reg;
    end
  endgenerate

  // AXI4-Lite write side: address and data are held until both have arrived
  assign o_s_axi_awready = ~aw_full_reg & ~bvalid_reg;
  assign o_s_axi_wready  = ~w_full_reg & ~bvalid_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;

  always @*
  begin
    ctrl_next = merge16(ctrl_reg, w_data_reg[15:0], w_strb_reg[1:0]);
  end

  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `AIF_RESP_OKAY;
      ctrl_reg    <= `AIF_CTRL_RST;
      lim1_reg    <= `AIF_LIM_RST;
      lim2_reg    <= `AIF_LIM_RST;
      upper_reg   <= `AIF_UPPER_RST;
      lower_reg   <= `AIF_LOWER_RST;
    end
    else
    begin
      if (o_s_axi_awready && i_s_axi_awvalid)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= i_s_axi_awaddr;
      end
      if (o_s_axi_wready && i_s_axi_wvalid)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= i_s_axi_wdata;
        w_strb_reg <= i_s_axi_wstrb;
      end
      if (bvalid_reg && i_s_axi_bready)
        bvalid_reg <= 1'b0;
      if (aw_full_reg && w_full_reg && !bvalid_reg)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= `AIF_RESP_OKAY;
        case ({aw_addr_reg[7:2], 2'b00})
          `AIF_OFS_CTRL:
          begin
            // Filter together with distributed clock is refused whole
            if (ctrl_next[`AIF_CTRL_FILT] && ctrl_next[`AIF_CTRL_DC])
              bresp_reg <= `AIF_RESP_SLVERR;
            else
              ctrl_reg <= ctrl_next;
          end
          `AIF_OFS_LIM1:
            lim1_reg <= merge16(lim1_reg, w_data_reg[15:0], w_strb_reg[1:0]);
          `AIF_OFS_LIM2:
            lim2_reg <= merge16(lim2_reg, w_data_reg[15:0], w_strb_reg[1:0]);
          `AIF_OFS_UPPER:
            upper_reg <= merge16(upper_reg, w_data_reg[15:0], w_strb_reg[1:0]);
          `AIF_OFS_LOWER:
            lower_reg <= merge16(lower_reg, w_data_reg[15:0], w_strb_reg[1:0]);
          default:
            bresp_reg <= `AIF_RESP_SLVERR;
        endcase
      end
    end
  end

  // AXI4-Lite read side
  assign rd_ch = i_s_axi_araddr[4:2];

  always @*
  begin
    rd_next    = 32'h00000000;
    rresp_next = `AIF_RESP_OKAY;
    if (i_s_axi_araddr[7:5] == `AIF_OFS_CHAN)
      rd_next = {img_sw_flat[16*rd_ch +: 16], img_val_flat[16*rd_ch +: 16]};
    else
    begin
      case ({i_s_axi_araddr[7:2], 2'b00})
        `AIF_OFS_CTRL:
          rd_next[15:0] = ctrl_reg;
        `AIF_OFS_STAT:
        begin
          rd_next[`AIF_STAT_FREERUN] = freerun_eff;
          rd_next[`AIF_STAT_FAST_OPERATION_OPTION]  = fast_operation_option_eff;
          rd_next[`AIF_STAT_DC]      = dc_on;
          rd_next[`AIF_STAT_BUSY]    = (state_reg != S_IDLE);
        end
        `AIF_OFS_LIM1:
          rd_next[15:0] = lim1_reg;
        `AIF_OFS_LIM2:
          rd_next[15:0] = lim2_reg;
        `AIF_OFS_UPPER:
          rd_next[15:0] = upper_reg;
        `AIF_OFS_LOWER:
          rd_next[15:0] = lower_reg;
        default:
          rresp_next = `AIF_RESP_SLVERR;
      endcase
    end
  end

  assign o_s_axi_arready = ~rvalid_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_s_axi_rresp   = rresp_reg;

  always @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `AIF_RESP_OKAY;
    end
    else if (!rvalid_reg && i_s_axi_arvalid)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_next;
      rresp_reg  <= rresp_next;
    end
    else if (rvalid_reg && i_s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign o_adc_start       = start_reg;
  assign o_image_update    = update_reg;
  assign o_image_value     = img_val_flat;
  assign o_image_status    = img_sw_flat;
  assign o_image_status_en = ~compact;
endmodule

// >>> aif_defs.vh
// Constants for the analog input filter and status block
`ifndef AIF_DEFS_VH
`define AIF_DEFS_VH
`define AIF_NCH             8
`define AIF_CLK_PERIOD_NS   25
`define AIF_T_FIR50_NS      625000
`define AIF_T_FIR60_NS      521000
`define AIF_T_IIR_NS        1000000
`define AIF_OFS_CTRL        8'h00
`define AIF_OFS_STAT        8'h04
`define AIF_OFS_LIM1        8'h08
`define AIF_OFS_LIM2        8'h0c
`define AIF_OFS_UPPER       8'h10
`define AIF_OFS_LOWER       8'h14
`define AIF_OFS_CHAN        3'h1
`define AIF_CTRL_FILT       0
`define AIF_CTRL_DC         1
`define AIF_CTRL_FAST       2
`define AIF_CTRL_COMPACT    3
`define AIF_CTRL_INV        4
`define AIF_CTRL_LIM1EN     5
`define AIF_CTRL_LIM2EN     6
`define AIF_CTRL_CHAR_LO    8
`define AIF_CTRL_CHAR_HI    11
`define AIF_CTRL_RST        16'h0000
`define AIF_LIM_RST         16'h0000
`define AIF_UPPER_RST       16'h7fff
`define AIF_LOWER_RST       16'h8000
`define AIF_CHAR_FIR60      4'h1
`define AIF_CHAR_IIR1       4'h2
`define AIF_CHAR_IIR8       4'h9
`define AIF_STAT_FREERUN    0
`define AIF_STAT_FAST_OPERATION_OPTION     1
`define AIF_STAT_DC         2
`define AIF_STAT_BUSY       3
`define AIF_SW_TOGGLE       15
`define AIF_SW_FAULT        14
`define AIF_SW_SYNC         13
`define AIF_SW_ERR          6
`define AIF_SW_LIM2         4
`define AIF_SW_LIM1         2
`define AIF_SW_OVER         1
`define AIF_SW_UNDER        0
`define AIF_LIM_OFF         2'h0
`define AIF_LIM_BELOW       2'h1
`define AIF_LIM_ABOVE       2'h2
`define AIF_LIM_EQUAL       2'h3
`define AIF_RESP_OKAY       2'h0
`define AIF_RESP_SLVERR     2'h2
`endif

// >>> aif_fs_chk.sv
// Concurrent checks on the sampling, publish and status outputs of the block
`timescale 1ns/10ps
module aif_fs_chk
(
  input wire         i_clock,
  input wire         i_arst_n,
  input wire         i_internal_fault,
  input wire         o_adc_start,
  input wire         i_adc_done,
  input wire         o_image_update,
  input wire [127:0] o_image_value,
  input wire [127:0] o_image_status,
  input wire         o_image_status_en
);
  logic err_ok;
  logic pad_zero;
  logic std_prev;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  always_comb
  begin
    err_ok = 1'b1;
    pad_zero = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      err_ok &= o_image_status[16*c+6] == (o_image_status[16*c+1] | o_image_status[16*c]);
      pad_zero &= o_image_status[16*c+7 +: 6] == 6'h00;
    end
  end

  // A compact capture zeroes the toggle, so the flip is only judged between standard captures
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      std_prev <= 1'b1;
    else if (o_image_update)
      std_prev <= o_image_status_en;
  end

  a_start_pulse: assert property (o_adc_start |=> !o_adc_start)
    else $error("adc start wider than one cycle");
  a_publish_lag: assert property (i_adc_done |=> !o_image_update ##1 o_image_update)
    else $error("image not published two cycles after done");
  a_update_pulse: assert property (o_image_update |=> !o_image_update)
    else $error("image update wider than one cycle");
  a_image_hold: assert property (!o_image_update |-> $stable(o_image_value) && $stable(o_image_status))
    else $error("image changed without update");
  a_toggle_flip: assert property (o_image_update && o_image_status_en && std_prev
    |-> o_image_status[15] != $past(o_image_status[15]))
    else $error("toggle bit did not flip on publish");
  a_fault_flag: assert property (o_image_update && o_image_status_en && $past(i_internal_fault)
    && $past(i_internal_fault, 2) |-> o_image_status[14])
    else $error("fault bit clear during internal fault");
  a_error_or: assert property (err_ok)
    else $error("error bit differs from range flags");
  a_spare_zero: assert property (pad_zero)
    else $error("unused status bits not zero");
  a_compact_zero: assert property (o_image_update && !o_image_status_en |-> o_image_status == 128'h0)
    else $error("status present in compact set");

  c_publish: cover property (i_adc_done ##2 o_image_update);
  c_compact: cover property (o_image_update && !o_image_status_en);
  c_fault: cover property (o_image_update && o_image_status[14]);
endmodule

// >>> aif_adc_model.sv
// Behavioural converter that answers each start with one set of channel words
`timescale 1ns/10ps
module aif_adc_model
(
  input  wire         i_clock,
  input  wire         i_start,
  input  wire [3:0]   i_delay,
  input  wire [127:0] i_level,
  output wire         o_done,
  output wire [127:0] o_data
);
  logic [3:0]   cnt = 4'h0;
  logic         done_q = 1'b0;
  logic [127:0] data_q = 128'h0;

  assign o_done = done_q;
  assign o_data = data_q;

  // Outside the done cycle the data lines flip every cycle, so a capture at the
  // wrong moment cannot match by accident
  always @(posedge i_clock)
  begin
    done_q <= 1'b0;
    data_q <= ~data_q;
    if (i_start)
      cnt <= i_delay;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    if (!i_start && cnt == 4'h1)
    begin
      done_q <= 1'b1;
      data_q <= i_level;
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench: register access, sampling triggers and status packing
`timescale 1ns/10ps
module tb_top;
  localparam int FIR50 = 20;
  localparam int FIR60 = 16;
  localparam int IIR   = 30;
  logic         i_clock;
  logic         i_arst_n;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata;
  logic         awvalid, wvalid, bready, arvalid, rready;
  wire          awready, wready, bvalid, arready, rvalid;
  wire  [1:0]   bresp, rresp;
  wire  [31:0]  rdata;
  logic         frame, dcs, sync_err, fault;
  logic [3:0]   delay;
  logic [127:0] level;
  wire          start, done, upd, img_en;
  wire  [127:0] adc_data, img_v, img_s;
  int           n_errors, checked, n_starts, cyc, last, gap;
  logic [3:0]   chr [4] = '{4'h0, 4'h1, 4'h2, 4'h9};
  int           per [4] = '{FIR50, FIR60, IIR, IIR};

  aif_filter_status #(.P_FIR50_CYC(FIR50), .P_FIR60_CYC(FIR60), .P_IIR_CYC(IIR)) i_dut
  (
    .i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awprot(3'h0), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arprot(3'h0), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_frame_strobe(frame), .i_dc_sync(dcs),
    .i_sync_error(sync_err), .i_internal_fault(fault), .o_adc_start(start),
    .i_adc_done(done), .i_adc_data(adc_data), .o_image_update(upd),
    .o_image_value(img_v), .o_image_status(img_s), .o_image_status_en(img_en)
  );

  aif_adc_model u_adc
  (
    .i_clock(i_clock), .i_start(start), .i_delay(delay), .i_level(level),
    .o_done(done), .o_data(adc_data)
  );

  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (start === 1'b1)
    begin
      gap <= cyc - last;
      last <= cyc;
      n_starts <= n_starts + 1;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check("write response", bresp, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
                        input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge i_clock);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check("read data", rdata & m, ed);
    check("read response", rresp, er);
  endtask

  // Next trigger only after the previous publish, so no value is collected twice
  task automatic sample(input int kind);
    int n;
    n = 0;
    frame <= (kind == 0);
    dcs <= (kind == 1);
    @(posedge i_clock);
    frame <= 1'b0;
    dcs <= 1'b0;
    @(posedge i_clock);
    if (kind < 2)
      check("adc start", start, 1);
    while (upd !== 1'b1 && n < 100)
    begin
      @(posedge i_clock);
      n++;
    end
    check("image update", n < 100, 1);
  endtask

  task automatic chk_ch(input int c, input logic [15:0] ev, input logic [15:0] es);
    check("image value", img_v[16*c +: 16], ev);
    check("image status", img_s[16*c +: 16], es);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    int n;
    {awaddr, wdata, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
    {frame, dcs, sync_err, fault} = '0;
    delay = 4'h1;
    level = {80'h0, 16'h0100, 16'he000, 16'h2000};
    {n_errors, checked, n_starts, cyc, last, gap} = '0;
    i_arst_n = 1'b0;
    repeat (3) @(posedge i_clock);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    rd_chk(8'h00, 32'hffff, 32'h0000, 2'h0);
    rd_chk(8'h10, 32'hffff, 32'h7fff, 2'h0);
    rd_chk(8'h14, 32'hffff, 32'h8000, 2'h0);
    rd_chk(8'h18, 32'hffffffff, 32'h0, 2'h2);
    wr_chk(8'h04, 32'h1, 2'h2);
    wr_chk(8'h10, 32'h1000, 2'h0);
    wr_chk(8'h14, 32'hf000, 2'h0);
    sample(0);
    chk_ch(0, 16'h2000, 16'h8042);
    chk_ch(1, 16'he000, 16'h8041);
    chk_ch(2, 16'h0100, 16'h8000);
    rd_chk(8'h20, 32'hffffffff, 32'h80422000, 2'h0);
    fault <= 1'b1;
    delay <= 4'h9;
    wr_chk(8'h08, 32'h0100, 2'h0);
    wr_chk(8'h0c, 32'h0200, 2'h0);
    wr_chk(8'h00, 32'h0060, 2'h0);
    sample(0);
    chk_ch(0, 16'h2000, 16'h406a);
    chk_ch(2, 16'h0100, 16'h401c);
    chk_ch(3, 16'h0000, 16'h4014);
    fault <= 1'b0;
    wr_chk(8'h00, 32'h0070, 2'h0);
    sample(0);
    chk_ch(0, 16'h2000, 16'h8056);
    chk_ch(2, 16'h0100, 16'h802c);
    wr_chk(8'h00, 32'h0008, 2'h0);
    sample(0);
    check("status enable", img_en, 0);
    chk_ch(1, 16'he000, 16'h0000);
    wr_chk(8'h00, 32'h0002, 2'h0);
    check("status enable", img_en, 1);
    n = n_starts;
    frame <= 1'b1;
    @(posedge i_clock);
    frame <= 1'b0;
    repeat (30) @(posedge i_clock);
    check("frame ignored", n_starts - n, 0);
    sync_err <= 1'b1;
    @(posedge i_clock);
    sync_err <= 1'b0;
    sample(1);
    check("sync flag", img_s[45], 1);
    sample(1);
    check("sync flag", img_s[45], 0);
    wr_chk(8'h00, 32'h0003, 2'h2);
    rd_chk(8'h00, 32'hffff, 32'h0002, 2'h0);
    wr_chk(8'h00, 32'h0005, 2'h0);
    rd_chk(8'h04, 32'h0007, 32'h0001, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr_chk(8'h00, {20'h0, chr[i], 8'h05}, 2'h0);
      repeat (3) sample(2);
      check("sample period", gap, per[i]);
      check("filtered value", img_v[15:0], 16'h2000);
      check("filtered value", img_v[31:16], 16'he000);
    end
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    tally_and_finish();
  end
endmodule

bind aif_filter_status aif_fs_chk u_chk
(
  .i_clock          (i_clock),
  .i_arst_n         (i_arst_n),
  .i_internal_fault (i_internal_fault),
  .o_adc_start      (o_adc_start),
  .i_adc_done       (i_adc_done),
  .o_image_update   (o_image_update),
  .o_image_value    (o_image_value),
  .o_image_status   (o_image_status),
  .o_image_status_en(o_image_status_en)
);
